// ### rtl/scp_buf2.sv
`timescale 1ns/1ns
`default_nettype none
module scp_buf2 #(
  parameter int W = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  scp_strm_if.snk   in_s,
  scp_strm_if.src   out_s
);
  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0]   cnt;
    logic         rdy;
    logic         vld;
  } scp_buf_t;

  localparam scp_buf_t BUF_RST = '{rdy: 1'b1, default: '0};

  scp_buf_t s;
  scp_buf_t n;
  logic     push;
  logic     pop;

  // Two entries, head is always the oldest word
  always_comb begin
    n    = s;
    push = in_s.valid & s.rdy;
    pop  = s.vld & out_s.ready;
    unique case (s.cnt)
      2'h0: begin
        if (push) begin
          n.head = in_s.data;
          n.cnt  = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          n.head = in_s.data;
        end else if (push) begin
          n.tail = in_s.data;
          n.cnt  = 2'h2;
        end else if (pop) begin
          n.cnt = 2'h0;
        end
      end
      2'h2: begin
        if (pop) begin
          n.head = s.tail;
          n.cnt  = 2'h1;
        end
      end
      default: n = BUF_RST;
    endcase
    n.rdy = (n.cnt != 2'h2);
    n.vld = (n.cnt != 2'h0);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= BUF_RST;
    end else begin
      s <= n;
    end
  end

  assign in_s.ready = s.rdy;
  assign out_s.valid = s.vld;
  assign out_s.data = s.head;
endmodule
`default_nettype wire

// ### rtl/scp_pkg.sv
package scp_pkg;

  // Clock and link timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int QTR_NS        = 2500;
  localparam int QTR_CYC       = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWR_MS        = 20;
  localparam int TWR_CYC       = (TWR_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TWR_W         = 18;
  localparam logic [TWR_W-1:0] TWR_CYC_DEF = TWR_W'(TWR_CYC);
  localparam logic [TWR_W-1:0] TWR_ONE     = 18'h0_0001;

  // Memory geometry
  localparam int ADDR_W      = 24;
  localparam int MEM_ADDR_W  = 17;
  localparam int LEN_W       = 18;
  localparam logic [LEN_W-1:0] PAGE_LEN = 18'h0_0080;
  localparam logic [LEN_W-1:0] LEN_ONE  = 18'h0_0001;
  localparam logic [7:0]       PAGE_SENT = 8'h80;

  // Device address code, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h5a;

  // Bit engine counts
  localparam logic [3:0] ACK_IDX = 4'h8;
  localparam logic [1:0] QPH_ONE = 2'h1;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_BIT   = 5'h04,
    ST_STOP  = 5'h08,
    ST_DONE  = 5'h10
  } scp_state_t;

  typedef enum logic [6:0] {
    SP_HDR_W = 7'h01,
    SP_ADDR2 = 7'h02,
    SP_ADDR1 = 7'h04,
    SP_ADDR0 = 7'h08,
    SP_WDATA = 7'h10,
    SP_HDR_R = 7'h20,
    SP_RDATA = 7'h40
  } scp_step_t;

  typedef enum logic [1:0] {
    OP_WRITE_PAGE = 2'h0,
    OP_READ_CUR   = 2'h1,
    OP_READ_RAND  = 2'h2
  } scp_op_t;

  typedef struct packed {
    scp_state_t         fsm;
    scp_step_t          step;
    scp_op_t            op;
    logic [1:0]         qph;
    logic [3:0]         bit_idx;
    logic [7:0]         shreg;
    logic [7:0]         cur;
    logic [ADDR_W-1:0]  addr;
    logic [LEN_W-1:0]   remain;
    logic [7:0]         sent;
    logic               ack;
    logic               wr_busy;
    logic [TWR_W-1:0]   twr_cnt;
    logic               scl;
    logic               sda_oe_n;
    logic               prog_en_n;
    logic               cmd_ready;
    logic               done;
    logic               err;
    logic               rd_push;
    logic [7:0]         rd_byte;
    logic               sda_m;
    logic               sda_s;
  } scp_ctl_t;

  localparam scp_ctl_t CTL_RST = '{fsm: ST_IDLE, step: SP_HDR_W, op: OP_WRITE_PAGE, scl: 1'b1,
                                   sda_oe_n: 1'b1, prog_en_n: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                                   default: '0};

  function automatic logic scp_is_hdr(input scp_step_t st);
    scp_is_hdr = (st == SP_HDR_W) || (st == SP_HDR_R);
  endfunction

endpackage

// ### rtl/scp_prog_ctl.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - Receiver acks low, refuses by releasing
// - Each byte ends in ack or stop
// - New driver owns data before rising clock
// - Address bytes go most significant first
// - Data bytes go least significant first
// - Address byte LSB one reads, zero writes
// - Three address bytes, each acked separately
// - Page write sends exactly 128 bytes
// - Write: start, header, address, data, stop
// - Poll header; on refusal restart, no stop
// - Hold programming mode through write cycle
// - Current read: header, byte, then stop
// - Random read: aborted write header, read
// - Data changes only while clock low
// - Start falls, stop rises, clock high
// - Programmer acks each wanted read byte
module scp_prog_ctl
  import scp_pkg::*;
#(
  parameter logic [6:0]       DEV_ADDR       = DEV_ADDR_DEF,
  parameter logic [TWR_W-1:0] WR_TIMEOUT_CYC = TWR_CYC_DEF,
  parameter int               QTR_DIV        = QTR_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              prog_mode_en,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire scp_op_t           cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [LEN_W-1:0]  cmd_total_byte_count,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  input  wire logic [7:0]        wr_data,
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic [7:0]             rd_data,
  output logic                   done,
  output logic                   err,
  output logic                   write_busy,
  output logic                   prog_serial_clock,
  input  wire logic              prog_serial_data_in,
  output logic                   prog_serial_data_out,
  output logic                   prog_serial_data_oe_n,
  output logic                   serial_prog_enable_n
);

  scp_ctl_t   s;
  scp_ctl_t   n;
  logic       tick;
  logic       stall;
  logic       wr_take;
  logic [7:0] tx_byte;

  scp_strm_if #(.W(8)) wr_in ();
  scp_strm_if #(.W(8)) wr_q ();
  scp_strm_if #(.W(8)) rd_in ();
  scp_strm_if #(.W(8)) rd_q ();

  scp_tick #(.DIV(QTR_DIV)) u_tick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tick    (tick)
  );

  scp_buf2 #(.W(8)) u_wr_buf (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .in_s    (wr_in),
    .out_s   (wr_q)
  );

  scp_buf2 #(.W(8)) u_rd_buf (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .in_s    (rd_in),
    .out_s   (rd_q)
  );

  assign wr_in.valid = wr_valid;
  assign wr_in.data  = wr_data;
  assign wr_ready    = wr_in.ready;
  assign rd_in.valid = s.rd_push;
  assign rd_in.data  = s.rd_byte;
  assign rd_q.ready  = rd_ready;
  assign rd_valid    = rd_q.valid;
  assign rd_data     = rd_q.data;

  assign wr_take = (s.fsm == ST_BIT) && (s.step == SP_WDATA) && (s.bit_idx == 4'h0) && (s.qph == 2'h0)
                   && tick && wr_q.valid;
  assign wr_q.ready = wr_take;

  // Byte to shift out for each step of a transfer
  function automatic logic [7:0] tx_sel(input scp_step_t st, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
    unique case (st)
      SP_HDR_W: tx_sel = {DEV_ADDR, 1'b0};
      SP_HDR_R: tx_sel = {DEV_ADDR, 1'b1};
      SP_ADDR2: tx_sel = a[23:16];
      SP_ADDR1: tx_sel = a[15:8];
      SP_ADDR0: tx_sel = a[7:0];
      default:  tx_sel = wd;
    endcase
  endfunction

  always_comb begin
    n         = s;
    tx_byte   = s.shreg;
    stall     = 1'b0;
    n.done    = 1'b0;
    n.rd_push = 1'b0;
    n.sda_m   = prog_serial_data_in;
    n.sda_s   = s.sda_m;
    n.prog_en_n = ~(prog_mode_en | s.wr_busy);
    if (s.wr_busy) begin
      n.twr_cnt = s.twr_cnt + TWR_ONE;
      if (s.twr_cnt == WR_TIMEOUT_CYC) begin
        n.wr_busy = 1'b0;
      end
    end
    unique case (s.fsm)
      ST_IDLE: begin
        n.cmd_ready = ~s.prog_en_n;
        if (cmd_valid && s.cmd_ready) begin
          n.cmd_ready = 1'b0;
          n.op        = cmd_op;
          n.addr      = {{(ADDR_W - MEM_ADDR_W){1'b0}}, cmd_addr[MEM_ADDR_W-1:0]};
          if (cmd_op == OP_WRITE_PAGE) begin
            n.remain = PAGE_LEN;
          end else if (cmd_total_byte_count == '0) begin
            n.remain = LEN_ONE;
          end else begin
            n.remain = cmd_total_byte_count;
          end
          n.step = (cmd_op == OP_READ_CUR) ? SP_HDR_R : SP_HDR_W;
          n.err  = 1'b0;
          n.sent = 8'h00;
          n.qph  = 2'h0;
          n.fsm  = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          n.qph = s.qph + QPH_ONE;
          unique case (s.qph)
            2'h0: n.sda_oe_n = 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe_n = 1'b0;
            2'h3: begin
              n.scl     = 1'b0;
              n.bit_idx = 4'h0;
              n.fsm     = ST_BIT;
            end
          endcase
        end
      end
      ST_BIT: begin
        if (tick && (s.qph == 2'h0) && (s.bit_idx == 4'h0)) begin
          if (s.step == SP_WDATA) begin
            stall = ~wr_q.valid;
          end
          if (s.step == SP_RDATA) begin
            stall = ~rd_in.ready;
          end
        end
        if (tick && !stall) begin
          n.qph = s.qph + QPH_ONE;
          unique case (s.qph)
            2'h0: begin
              if (s.bit_idx == ACK_IDX) begin
                if (s.step == SP_RDATA) begin
                  n.sda_oe_n = (s.remain == LEN_ONE);
                  n.rd_push  = 1'b1;
                  n.rd_byte  = s.shreg;
                end else begin
                  n.sda_oe_n = 1'b1;
                end
              end else if (s.step == SP_RDATA) begin
                n.sda_oe_n = 1'b1;
              end else begin
                if (s.bit_idx == 4'h0) begin
                  tx_byte = tx_sel(s.step, s.addr, wr_q.data);
                  n.cur   = tx_byte;
                end
                if (s.step == SP_WDATA) begin
                  n.sda_oe_n = tx_byte[0];
                  n.shreg    = {1'b0, tx_byte[7:1]};
                end else begin
                  n.sda_oe_n = tx_byte[7];
                  n.shreg    = {tx_byte[6:0], 1'b0};
                end
              end
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (s.bit_idx == ACK_IDX) begin
                n.ack = ~s.sda_s;
              end else if (s.step == SP_RDATA) begin
                n.shreg = {s.sda_s, s.shreg[7:1]};
              end
            end
            2'h3: begin
              n.scl = 1'b0;
              if (s.bit_idx != ACK_IDX) begin
                n.bit_idx = s.bit_idx + 4'h1;
              end else begin
                n.bit_idx = 4'h0;
                if (scp_is_hdr(s.step)) begin
                  if (s.ack) begin
                    n.wr_busy = 1'b0;
                    n.step    = (s.step == SP_HDR_W) ? SP_ADDR2 : SP_RDATA;
                  end else if (s.wr_busy) begin
                    n.fsm = ST_START;
                  end else begin
                    n.err = 1'b1;
                    n.fsm = ST_STOP;
                  end
                end else if (!s.ack && (s.step != SP_RDATA)) begin
                  n.err = 1'b1;
                  n.fsm = ST_STOP;
                end else begin
                  unique case (s.step)
                    SP_ADDR2: n.step = SP_ADDR1;
                    SP_ADDR1: n.step = SP_ADDR0;
                    SP_ADDR0: begin
                      if (s.op == OP_READ_RAND) begin
                        n.step = SP_HDR_R;
                        n.fsm  = ST_START;
                      end else begin
                        n.step = SP_WDATA;
                      end
                    end
                    SP_WDATA: begin
                      n.remain = s.remain - LEN_ONE;
                      n.sent   = s.sent + 8'h01;
                      if (s.remain == LEN_ONE) begin
                        n.fsm = ST_STOP;
                      end
                    end
                    SP_RDATA: begin
                      n.remain = s.remain - LEN_ONE;
                      if (s.remain == LEN_ONE) begin
                        n.fsm = ST_STOP;
                      end
                    end
                    default: n.fsm = ST_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          n.qph = s.qph + QPH_ONE;
          unique case (s.qph)
            2'h0: n.sda_oe_n = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe_n = 1'b1;
            2'h3: begin
              n.fsm = ST_DONE;
              if (s.step == SP_WDATA) begin
                n.wr_busy = 1'b1;
                n.twr_cnt = '0;
              end
            end
          endcase
        end
      end
      ST_DONE: begin
        if (tick) begin
          n.fsm  = ST_IDLE;
          n.done = 1'b1;
        end
      end
      default: n = CTL_RST;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= CTL_RST;
    end else begin
      s <= n;
    end
  end

  assign cmd_ready             = s.cmd_ready;
  assign done                  = s.done;
  assign err                   = s.err;
  assign write_busy            = s.wr_busy;
  assign prog_serial_clock     = s.scl;
  assign prog_serial_data_out  = 1'b0;
  assign prog_serial_data_oe_n = s.sda_oe_n;
  assign serial_prog_enable_n  = s.prog_en_n;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_sda_quiet_high: assert property ((s.fsm == ST_BIT) && s.scl && $past(s.scl) |-> $stable(s.sda_oe_n))
    else $error("data moved while clock high inside a bit");
  a_start_edge: assert property ($fell(s.sda_oe_n) && (s.fsm == ST_START) |-> s.scl && $past(s.scl))
    else $error("start edge without clock high");
  a_stop_edge: assert property ($rose(s.sda_oe_n) && (s.fsm == ST_STOP) |-> s.scl && $past(s.scl))
    else $error("stop edge without clock high");
  a_ack_release: assert property ((s.fsm == ST_BIT) && (s.bit_idx == ACK_IDX) && (s.step != SP_RDATA) && s.scl
                                  |-> s.sda_oe_n)
    else $error("data held low during device ack bit");
  a_host_ack_read: assert property ((s.fsm == ST_BIT) && (s.bit_idx == ACK_IDX) && (s.step == SP_RDATA) && s.scl
                                    |-> (s.sda_oe_n == (s.remain == LEN_ONE)))
    else $error("wrong ack level after read byte");
  a_addr_msb_first: assert property ((s.fsm == ST_BIT) && $rose(s.scl) && (s.bit_idx != ACK_IDX)
                                     && (s.step != SP_WDATA) && (s.step != SP_RDATA)
                                     |-> (s.sda_oe_n == s.cur[3'd7 - s.bit_idx[2:0]]))
    else $error("address bit order wrong");
  a_data_lsb_first: assert property ((s.fsm == ST_BIT) && $rose(s.scl) && (s.bit_idx != ACK_IDX)
                                     && (s.step == SP_WDATA) |-> (s.sda_oe_n == s.cur[s.bit_idx[2:0]]))
    else $error("data bit order wrong");
  a_dir_bit: assert property ((s.fsm == ST_BIT) && scp_is_hdr(s.step) && s.scl
                              |-> (s.cur[0] == (s.step == SP_HDR_R)))
    else $error("direction bit wrong in header");
  a_page_len: assert property ((s.fsm == ST_STOP) && (s.step == SP_WDATA) && !s.err |-> (s.sent == PAGE_SENT))
    else $error("page write not 128 bytes");
  a_retry_no_stop: assert property ((s.fsm == ST_BIT) && tick && (s.qph == 2'h3) && (s.bit_idx == ACK_IDX)
                                    && scp_is_hdr(s.step) && !s.ack && s.wr_busy |=> (s.fsm == ST_START))
    else $error("poll refusal not followed by restart");
  a_busy_holds_en: assert property (s.wr_busy |=> !s.prog_en_n)
    else $error("programming mode left during write cycle");

endmodule
`default_nettype wire

// ### rtl/scp_strm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface scp_strm_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/scp_tick.sv
`timescale 1ns/1ns
`default_nettype none
module scp_tick
  import scp_pkg::*;
#(
  parameter int DIV = QTR_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  output logic      tick
);
  localparam int CW = $clog2(DIV + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } scp_tick_t;

  scp_tick_t s;
  scp_tick_t n;

  // Quarter-bit enable pulse
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt == CW'(DIV - 1)) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

// ### verification/scp_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module scp_dev_model #(
  parameter logic [6:0] DEV_ADDR = 7'h5a,  // Value is arbitrary
  parameter int         BUSY_NS  = 150000
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic en_n,
  input  wire logic mute,
  output logic      pull,
  output logic      viol
);
  localparam logic [2:0] PH_HDR = 3'h0;
  localparam logic [2:0] PH_WD  = 3'h4;
  localparam logic [2:0] PH_RD  = 3'h5;
  localparam logic [2:0] PH_IGN = 3'h6;
  logic [7:0]  mem [int];
  logic [7:0]  shreg;
  logic [7:0]  rbyte;
  logic [16:0] cur;
  logic [3:0]  bitcnt;
  logic [2:0]  phase;
  logic        wrote;
  logic        accept;
  int          nbytes;
  time         busy_until;

  // Blank array reads as zero
  function automatic logic [7:0] rd_mem(input logic [16:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'h00;
  endfunction

  initial begin
    pull = 1'b0;
    viol = 1'b0;
    phase = PH_IGN;
    bitcnt = 4'h0;
    cur = '0;
    wrote = 1'b0;
    busy_until = 0;
  end

  always @(negedge sda) begin
    if (scl === 1'b1) begin
      phase = PH_HDR;
      bitcnt = 4'h0;
      nbytes = 0;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1 && wrote) begin
      busy_until = $time + BUSY_NS;
      if (cur[6:0] == 7'h00) cur = cur + 17'h0_0080;
      if (nbytes != 128) viol = 1'b1;
      wrote = 1'b0;
    end
    if (scl === 1'b1) phase = PH_IGN;
  end

  always @(posedge en_n) begin
    if ($time < busy_until) viol = 1'b1;
  end

  always @(posedge scl) begin
    if (!en_n && phase != PH_IGN) begin
      if (bitcnt == 4'h8) begin
        bitcnt = 4'h0;
        if (phase == PH_RD && sda == 1'b0) begin
          rbyte = rd_mem(cur);
          cur = cur + 17'h0_0001;
        end else if (phase == PH_RD) begin
          phase = PH_IGN;
        end
      end else begin
        shreg = (phase == PH_WD) ? {sda, shreg[7:1]} : {shreg[6:0], sda};
        bitcnt = bitcnt + 4'h1;
      end
    end
  end

  always @(negedge scl) begin
    if (en_n || phase == PH_IGN) begin
      pull <= 1'b0;
    end else if (phase == PH_RD) begin
      pull <= bitcnt < 4'h8 && !rbyte[bitcnt[2:0]];
    end else if (bitcnt != 4'h8) begin
      pull <= 1'b0;
    end else begin
      accept = 1'b1;
      case (phase)
        PH_HDR: begin
          if (mute || $time < busy_until || shreg[7:1] != DEV_ADDR) accept = 1'b0;
          else if (shreg[0]) phase = PH_RD;
          else phase = 3'h1;
        end
        3'h1: begin
          cur[16] = shreg[0];
          phase = 3'h2;
        end
        3'h2: begin
          cur[15:8] = shreg;
          phase = 3'h3;
        end
        3'h3: begin
          cur[7:0] = shreg;
          phase = PH_WD;
        end
        default: begin
          mem[int'(cur)] = shreg;
          cur[6:0] = cur[6:0] + 7'h01;
          wrote = 1'b1;
          nbytes++;
        end
      endcase
      if (!accept) phase = PH_IGN;
      pull <= accept;
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import scp_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst_b;
  logic              prog_mode_en;
  logic              cmd_valid;
  logic              cmd_ready;
  scp_op_t           cmd_op;
  logic [ADDR_W-1:0] cmd_addr;
  logic [LEN_W-1:0]  cmd_total_byte_count;
  logic              wr_valid;
  logic              wr_ready;
  logic [7:0]        wr_data;
  logic              rd_valid;
  logic              rd_ready;
  logic [7:0]        rd_data;
  logic              done;
  logic              err;
  logic              write_busy;
  logic              scl;
  logic              sda;
  logic              sda_oe_n;
  logic              sda_out;
  logic              en_n;
  logic              pull;
  logic              viol;
  logic              mute;
  logic [7:0]        rq [$];
  int                error_cnt = 0;
  int                cmp_count = 0;

  always #50 sys_clk = ~sys_clk;
  // Pulled-up data line
  assign sda = (pull || !sda_oe_n) ? 1'b0 : 1'b1;

  scp_prog_ctl #(.DEV_ADDR(DEV_ADDR_DEF), .WR_TIMEOUT_CYC(18'h0_0bb8), .QTR_DIV(10)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .prog_mode_en(prog_mode_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_total_byte_count(cmd_total_byte_count), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .done(done), .err(err), .write_busy(write_busy), .prog_serial_clock(scl),
    .prog_serial_data_in(sda), .prog_serial_data_out(sda_out), .prog_serial_data_oe_n(sda_oe_n),
    .serial_prog_enable_n(en_n));

  scp_dev_model #(.DEV_ADDR(DEV_ADDR_DEF), .BUSY_NS(150000)) u_dev (
    .scl(scl), .sda(sda), .en_n(en_n), .mute(mute), .pull(pull), .viol(viol));

  function automatic logic [7:0] wdat(input int i);
    return 8'(i * 29) ^ 8'h6c;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic run_cmd(input scp_op_t op, input logic [23:0] addr, input logic [17:0] cnt);
    int n;
    int widx;
    bit fin;
    bit tk;
    bit wt;
    widx = 0;
    fin = 1'b0;
    rq.delete();
    cmd_op = op;
    cmd_addr = addr;
    cmd_total_byte_count = cnt;
    cmd_valid = 1'b1;
    for (n = 0; n < 200000 && !fin; n++) begin
      @(posedge sys_clk);
      tk = cmd_valid && cmd_ready;
      wt = wr_valid && wr_ready;
      if (rd_valid && rd_ready) rq.push_back(rd_data);
      fin = done;
      #1;
      if (tk) cmd_valid = 1'b0;
      if (wt) widx++;
      if (wt || !wr_valid) begin
        wr_valid = op == OP_WRITE_PAGE && widx < 128 && n % 9 != 4;
        wr_data = wdat(widx);
      end
      rd_ready = n > 1500;
    end
    if (!fin) begin
      $display("FAIL done expected 1 seen 0");
      error_cnt++;
      conclude();
    end
  endtask

  task automatic t_reset();
    check("clock idle", scl, 8'h01);
    check("data released", sda_oe_n, 8'h01);
    check("data out low", sda_out, 8'h00);
    check("mode off", en_n, 8'h01);
    check("cmd_ready", cmd_ready, 8'h00);
    check("write_busy", write_busy, 8'h00);
    prog_mode_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check("mode on", en_n, 8'h00);
    check("cmd_ready on", cmd_ready, 8'h01);
    $display("test reset done");
  endtask

  task automatic t_page_write();
    int idx [4] = '{0, 111, 112, 127};
    run_cmd(OP_WRITE_PAGE, 24'h00_0390, 18'h0_0000);
    check("write err", err, 8'h00);
    check("busy after stop", write_busy, 8'h01);
    check("page length", viol, 8'h00);
    foreach (idx[k]) check("stored", u_dev.rd_mem(17'h0_0380 + 17'((idx[k] + 16) % 128)), wdat(idx[k]));
    prog_mode_en = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check("mode held", en_n, 8'h00);
    prog_mode_en = 1'b1;
    $display("test page write done");
  endtask

  task automatic t_poll_read();
    run_cmd(OP_READ_CUR, 24'h00_0000, 18'h0_0003);
    check("poll err", err, 8'h00);
    check("busy cleared", write_busy, 8'h00);
    check("count", 8'(rq.size()), 8'h03);
    for (int k = 0; k < 3; k++) check("cur read", rq[k], wdat(k));
    check("mode kept", viol, 8'h00);
    $display("test poll read done");
  endtask

  task automatic t_rand_read();
    run_cmd(OP_READ_RAND, 24'h00_03ff, 18'h0_0002);
    check("count", 8'(rq.size()), 8'h02);
    check("page end", rq[0], wdat(111));
    check("next addr", rq[1], 8'h00);
    run_cmd(OP_READ_RAND, 24'h00_0380, 18'h0_0000);
    check("count", 8'(rq.size()), 8'h01);
    check("page base", rq[0], wdat(112));
    $display("test random read done");
  endtask

  task automatic t_refuse();
    mute = 1'b1;
    run_cmd(OP_READ_CUR, 24'h00_0000, 18'h0_0001);
    check("refused err", err, 8'h01);
    check("no data", 8'(rq.size()), 8'h00);
    mute = 1'b0;
    $display("test refuse done");
  endtask

  initial begin
    rst_b = 1'b0;
    prog_mode_en = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_WRITE_PAGE;
    cmd_addr = '0;
    cmd_total_byte_count = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_ready = 1'b0;
    mute = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_page_write();
    t_poll_read();
    t_rand_read();
    t_refuse();
    conclude();
  end
endmodule
`default_nettype wire
